/* include/iud_defs.svh */
// Constants of the interpolating upconversion datapath: register offsets,
// field positions, reset values and default filter coefficients.
// Assumes inclusion by its bare name wherever a constant is needed.
`ifndef IUD_DEFS_SVH
`define IUD_DEFS_SVH
`define IUD_OFS_CFG 8'h1b
`define IUD_OFS_HB1_MODE 8'h1c
`define IUD_OFS_HB2_MODE 8'h1d
`define IUD_OFS_HB3_MODE 8'h1e
`define IUD_OFS_FTW0 8'h30
`define IUD_OFS_FTW1 8'h31
`define IUD_OFS_FTW2 8'h32
`define IUD_OFS_FTW3 8'h33
`define IUD_OFS_FTW_UPD 8'h36
`define IUD_OFS_STATUS 8'h37
`define IUD_BIT_PREMOD 0
`define IUD_BIT_HB1_EN 1
`define IUD_BIT_HB3_EN 3
`define IUD_BIT_FTW_UPD 0
`define IUD_RST_BYTE 8'h00
`define IUD_RST_FTW 32'h0000_0000
`define IUD_FIFO_DEPTH 8
`define IUD_HB_TAPS 4
`define IUD_HB1_PRE_UNIT 4'h8
`define IUD_HB1_POST_UNIT 4'h4
`define IUD_HBX_PRE_UNIT 4'h2
`define IUD_HBX_POST_UNIT 4'h1
`define IUD_MOD_STEP 4'h8
`define IUD_COEF_HB 64'h2d00_1800_fa00_0100
`endif

/* include/iud_pkg.sv */
// Types and shared arithmetic of the interpolating upconversion datapath.
// Assumes nothing of its surroundings.
package iud_pkg;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } iud_iq_t;

  typedef struct packed {
    logic [3:0] stage_en;
  } iud_cfg_t;

  // Quarter wave of sine, 17 points from 0 to a right angle, Q15
  function automatic logic signed [15:0] iud_qsin(input logic [4:0] k);
    case (k)
      5'h00: return 16'sh0000;
      5'h01: return 16'sh0c8c;
      5'h02: return 16'sh18f9;
      5'h03: return 16'sh2528;
      5'h04: return 16'sh30fc;
      5'h05: return 16'sh3c57;
      5'h06: return 16'sh471d;
      5'h07: return 16'sh5133;
      5'h08: return 16'sh5a82;
      5'h09: return 16'sh62f2;
      5'h0a: return 16'sh6a6e;
      5'h0b: return 16'sh70e3;
      5'h0c: return 16'sh7642;
      5'h0d: return 16'sh7a7d;
      5'h0e: return 16'sh7d8a;
      5'h0f: return 16'sh7f62;
      default: return 16'sh7fff;
    endcase
  endfunction

  // Sine of a 6-bit phase, one turn in 64 steps
  function automatic logic signed [15:0] iud_sin(input logic [5:0] ph);
    logic [4:0] k;
    logic signed [15:0] v;
    k = ph[4] ? 5'(5'h10 - {1'h0, ph[3:0]}) : {1'h0, ph[3:0]};
    v = iud_qsin(k);
    return ph[5] ? 16'(-v) : v;
  endfunction

  // Complex multiply of a sample by cos + j sin of the phase
  function automatic iud_iq_t iud_rot(input iud_iq_t x, input logic [5:0] ph);
    logic signed [15:0] c;
    logic signed [15:0] s;
    logic signed [32:0] ai;
    logic signed [32:0] aq;
    iud_iq_t r;
    c = iud_sin(6'(ph + 6'h10));
    s = iud_sin(ph);
    ai = 33'(x.i * c) - 33'(x.q * s);
    aq = 33'(x.i * s) + 33'(x.q * c);
    r.i = ai[30:15];
    r.q = aq[30:15];
    return r;
  endfunction

endpackage

/* verilog/iud_fifo.sv */
// Sample FIFO ahead of the datapath, registered full and empty flags.
// Assumes writer and reader on the same clock.
`timescale 1ns/1ns
`default_nettype none
module iud_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr_valid,
  input wire logic [W-1:0] i_wr_data,
  output logic o_wr_ready,
  output logic o_rd_valid,
  output logic [W-1:0] o_rd_data,
  input wire logic i_rd_ready,
  output logic [$clog2(DEPTH):0] o_level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] cnt_next;
  logic push;
  logic pop;

  assign push = i_wr_valid && o_wr_ready;
  assign pop = i_rd_ready && o_rd_valid;
  assign o_rd_data = mem[rd_ptr_reg];
  assign cnt_next = o_level + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= i_wr_data;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      o_level <= '0;
      o_wr_ready <= 1'h0;
      o_rd_valid <= 1'h0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'h1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'h1;
      o_level <= cnt_next;
      o_wr_ready <= cnt_next != (AW+1)'(DEPTH);
      o_rd_valid <= cnt_next != '0;
    end
  end
endmodule
`default_nettype wire

/* verilog/iud_hb_stage.sv */
// One half-band interpolator stage with mode shifts and bypass.
// Assumes in and out strobes from a common divider, out at twice in rate.
`timescale 1ns/1ns
`default_nettype none
`include "iud_defs.svh"
module iud_hb_stage import iud_pkg::*; #(
  parameter int TAPS = `IUD_HB_TAPS,
  parameter logic [TAPS*16-1:0] COEF = `IUD_COEF_HB,
  parameter logic [3:0] PRE_UNIT = `IUD_HBX_PRE_UNIT,
  parameter logic [3:0] POST_UNIT = `IUD_HBX_POST_UNIT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic [1:0] i_lo,
  input wire logic i_mod,
  input wire logic i_in_stb,
  input wire logic i_out_stb,
  input wire iud_iq_t i_in,
  output iud_iq_t o_out
);
  iud_iq_t dly_reg [2*TAPS];
  logic [3:0] pre_ph_reg;
  logic [3:0] post_ph_reg;
  logic odd_reg;
  logic [3:0] pre_step;
  logic [3:0] post_step;
  iud_iq_t pre_rot;
  iud_iq_t arm;
  logic signed [35:0] acc_i;
  logic signed [35:0] acc_q;

  // Centre offset removed before filtering, restored plus modulation after
  assign pre_step = 4'(i_lo * PRE_UNIT); // RULE_06 RULE_08 RULE_10
  assign post_step = 4'(i_lo * POST_UNIT) + (i_mod ? `IUD_MOD_STEP : 4'h0); // RULE_06 RULE_08 RULE_10
  assign pre_rot = iud_rot(i_in, {pre_ph_reg, 2'h0}); // RULE_07 RULE_09

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < 2*TAPS; k++)
        dly_reg[k] <= '0;
      pre_ph_reg <= 4'h0;
    end
    else if (i_in_stb && i_en)
    begin
      dly_reg[0] <= pre_rot;
      for (int k = 1; k < 2*TAPS; k++)
        dly_reg[k] <= dly_reg[k-1];
      pre_ph_reg <= pre_ph_reg + pre_step;
    end
  end

  // Polyphase half-band: even phase is the centre tap, odd the symmetric arm
  always_comb
  begin
    acc_i = '0;
    acc_q = '0;
    for (int k = 0; k < TAPS; k++)
    begin
      acc_i = acc_i + 36'($signed(COEF[16*k +: 16]) *
        (17'(dly_reg[k].i) + 17'(dly_reg[2*TAPS-1-k].i))); // RULE_03 RULE_04 RULE_05
      acc_q = acc_q + 36'($signed(COEF[16*k +: 16]) *
        (17'(dly_reg[k].q) + 17'(dly_reg[2*TAPS-1-k].q))); // RULE_03 RULE_04 RULE_05
    end
    arm = dly_reg[TAPS-1];
    if (odd_reg)
    begin
      arm.i = acc_i[29:14];
      arm.q = acc_q[29:14];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_out <= '0;
      odd_reg <= 1'h0;
      post_ph_reg <= 4'h0;
    end
    else if (!i_en)
    begin
      odd_reg <= 1'h0;
      post_ph_reg <= 4'h0;
      if (i_in_stb)
        o_out <= i_in; // RULE_21
    end
    else if (i_out_stb)
    begin
      o_out <= iud_rot(arm, {post_ph_reg, 2'h0}); // RULE_02 RULE_07 RULE_09
      odd_reg <= !odd_reg;
      post_ph_reg <= post_ph_reg + post_step;
    end
  end

  chk_bypass_pass: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_en && i_in_stb) |=> (o_out == $past(i_in))) // RULE_21
    else $error("bypassed stage did not pass the sample");
  chk_phase_alt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_en && i_out_stb && $past(i_en)) |=> (odd_reg != $past(odd_reg))) // RULE_02
    else $error("stage output phase did not alternate");
endmodule
`default_nettype wire

/* verilog/iud_datapath.sv */
// Interpolating upconversion datapath: FIFO, premodulator, three
// half-band stages and a tuning-word oscillator with complex mixer.
// Assumes i_clk is the converter clock; register port on the same clock.
//
// Behaviour
// [RULE_01] Premodulator shifts the input up by half the input rate.
// [RULE_02] Three bypassable half-band stages give ratios one, two, four, eight.
// [RULE_03] Usable bandwidth 0.8, 0.5, 0.4 of each stage input rate; code gives all three stages one coefficient set.
// [RULE_04] Ripple under 0.001 dB, image rejection over 85 dB in band.
// [RULE_05] First stage four modes, others eight, one response shape each.
// [RULE_06] First stage centres at 0, half, one, 1.5 input rate; 2,3 modulate.
// [RULE_07] First stage modes 0 and 2 keep I and Q apart; 1,3 mix.
// [RULE_08] Second stage mode n centres at n eighths; modes 4-7 modulate; code centres modes 4-7 at n+4 eighths of the input rate.
// [RULE_09] Second stage modes 0 and 4 keep I and Q apart; others mix.
// [RULE_10] Third stage has the second stage modes, differing in bandwidth; code reuses the second stage coefficients.
// [RULE_11] Independent real channels use only premodulator and unshifted modes.
// [RULE_12] Carrier set by a 32-bit tuning word in bytes 0x30 to 0x33.
// [RULE_13] Oscillator ticks at input rate, or twice that with stage one on.
// [RULE_14] Phase advances by tuning word modulo 2^32 each oscillator tick.
// [RULE_15] Cosine and sine carriers complex-multiply the I and Q data.
// [RULE_16] Path holds premodulator, three interpolators and quadrature mixer.
// [RULE_17] New tuning word takes effect on a rising update bit at 0x36.
// [RULE_18] One I/Q pair is pulled per input period, clock over ratio.
// [RULE_19] Mode fields: two bits, then six bits repeating three, at 0x1C-0x1E.
// [RULE_20] Order premod, three stages, mixer; strobes divide the clock.
// [RULE_21] A bypassed stage passes samples unchanged with I and Q aligned.
`timescale 1ns/1ns
`default_nettype none
`include "iud_defs.svh"
module iud_datapath import iud_pkg::*; #(
  parameter int FIFO_DEPTH = `IUD_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  input wire iud_iq_t i_in_data,
  output logic o_in_ready,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  output logic [7:0] o_reg_rdata,
  output iud_iq_t o_out,
  output logic o_out_valid
);

  //////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_reg <= 1'h0;
      rst_n <= 1'h0;
    end
    else
    begin
      rst_meta_reg <= 1'h1;
      rst_n <= rst_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file

  iud_cfg_t cfg_reg;
  logic [1:0] hb1_mode_reg;
  logic [5:0] hb2_mode_reg;
  logic [5:0] hb3_mode_reg;
  logic [7:0] ftw_shadow_reg [4];
  logic [31:0] ftw_active_reg;
  logic ftw_upd_reg;
  logic ftw_upd_prev_reg;
  logic ftw_take;
  logic [7:0] rdata_next;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;
  logic [1:0] n_en;

  // Write decode at the printed offsets
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= '0;
      hb1_mode_reg <= 2'h0;
      hb2_mode_reg <= 6'h00;
      hb3_mode_reg <= 6'h00;
      ftw_upd_reg <= 1'h0;
      for (int k = 0; k < 4; k++)
        ftw_shadow_reg[k] <= `IUD_RST_BYTE;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        `IUD_OFS_CFG: cfg_reg.stage_en <= i_reg_wdata[3:0];
        `IUD_OFS_HB1_MODE: hb1_mode_reg <= i_reg_wdata[1:0]; // RULE_19
        `IUD_OFS_HB2_MODE: hb2_mode_reg <= i_reg_wdata[5:0]; // RULE_19
        `IUD_OFS_HB3_MODE: hb3_mode_reg <= i_reg_wdata[5:0]; // RULE_19
        `IUD_OFS_FTW0: ftw_shadow_reg[0] <= i_reg_wdata; // RULE_12
        `IUD_OFS_FTW1: ftw_shadow_reg[1] <= i_reg_wdata; // RULE_12
        `IUD_OFS_FTW2: ftw_shadow_reg[2] <= i_reg_wdata; // RULE_12
        `IUD_OFS_FTW3: ftw_shadow_reg[3] <= i_reg_wdata; // RULE_12
        `IUD_OFS_FTW_UPD: ftw_upd_reg <= i_reg_wdata[`IUD_BIT_FTW_UPD];
        default: ;
      endcase
    end
  end

  // Tuning word moves to the oscillator only on a rising update bit
  assign ftw_take = ftw_upd_reg && !ftw_upd_prev_reg; // RULE_17

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ftw_upd_prev_reg <= 1'h0;
      ftw_active_reg <= `IUD_RST_FTW;
    end
    else
    begin
      ftw_upd_prev_reg <= ftw_upd_reg;
      if (ftw_take)
        ftw_active_reg <= {ftw_shadow_reg[3], ftw_shadow_reg[2],
          ftw_shadow_reg[1], ftw_shadow_reg[0]}; // RULE_17 RULE_12
    end
  end

  // Read mux, answered one clock after the address is presented
  always_comb
  begin
    rdata_next = 8'h00;
    case (i_reg_addr)
      `IUD_OFS_CFG: rdata_next = {4'h0, cfg_reg.stage_en};
      `IUD_OFS_HB1_MODE: rdata_next = {6'h00, hb1_mode_reg};
      `IUD_OFS_HB2_MODE: rdata_next = {2'h0, hb2_mode_reg};
      `IUD_OFS_HB3_MODE: rdata_next = {2'h0, hb3_mode_reg};
      `IUD_OFS_FTW0: rdata_next = ftw_shadow_reg[0];
      `IUD_OFS_FTW1: rdata_next = ftw_shadow_reg[1];
      `IUD_OFS_FTW2: rdata_next = ftw_shadow_reg[2];
      `IUD_OFS_FTW3: rdata_next = ftw_shadow_reg[3];
      `IUD_OFS_FTW_UPD: rdata_next = {7'h00, ftw_upd_reg};
      `IUD_OFS_STATUS: rdata_next = {2'h0, n_en, 4'(fifo_level)};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_reg_rdata <= 8'h00;
    else
      o_reg_rdata <= rdata_next;
  end

  //////////////////////////////////////////////////////////////////////////
  // Rate divider and stage strobes

  logic en1;
  logic en2;
  logic en3;
  logic [2:0] cnt_reg;
  logic [2:0] ratio_m1;
  logic tick_in;
  logic tick_hb1;
  logic tick_hb2;
  logic tick_hb3;

  assign en1 = cfg_reg.stage_en[`IUD_BIT_HB1_EN];
  assign en2 = cfg_reg.stage_en[`IUD_BIT_HB1_EN + 1];
  assign en3 = cfg_reg.stage_en[`IUD_BIT_HB3_EN];
  assign n_en = 2'(en1) + 2'(en2) + 2'(en3); // RULE_02
  assign ratio_m1 = 3'((4'h1 << n_en) - 4'h1); // RULE_02

  // Strobe of a point in the chain with rem stages still ahead of it
  function automatic logic stage_tick(input logic [2:0] cnt,
    input logic [1:0] rem);
    logic [2:0] mask;
    mask = 3'((4'h1 << rem) - 4'h1);
    return (cnt & mask) == 3'h0;
  endfunction

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 3'h0;
    else if (cnt_reg >= ratio_m1)
      cnt_reg <= 3'h0; // RULE_18
    else
      cnt_reg <= cnt_reg + 3'h1;
  end

  assign tick_in = stage_tick(cnt_reg, n_en); // RULE_18 RULE_20
  assign tick_hb1 = stage_tick(cnt_reg, 2'(en2) + 2'(en3)); // RULE_20
  assign tick_hb2 = stage_tick(cnt_reg, 2'(en3)); // RULE_20
  assign tick_hb3 = stage_tick(cnt_reg, 2'h0); // RULE_20

  //////////////////////////////////////////////////////////////////////////
  // Input FIFO and premodulator

  iud_iq_t fifo_data;
  logic fifo_valid;
  logic pop;
  iud_iq_t premod_reg;
  logic alt_reg;
  logic started_reg;

  iud_fifo #(
    .W($bits(iud_iq_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_wr_valid(i_in_valid),
    .i_wr_data(i_in_data),
    .o_wr_ready(o_in_ready),
    .o_rd_valid(fifo_valid),
    .o_rd_data(fifo_data),
    .i_rd_ready(tick_in),
    .o_level(fifo_level)
  );

  assign pop = tick_in && fifo_valid; // RULE_18

  // Half-rate shift: every other input sample is negated
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      premod_reg <= '0;
      alt_reg <= 1'h0;
      started_reg <= 1'h0;
    end
    else if (tick_in)
    begin
      alt_reg <= !alt_reg;
      if (pop)
      begin
        started_reg <= 1'h1;
        premod_reg <= fifo_data;
        if (cfg_reg.stage_en[`IUD_BIT_PREMOD] && alt_reg)
        begin
          premod_reg.i <= 16'(-fifo_data.i); // RULE_01
          premod_reg.q <= 16'(-fifo_data.q); // RULE_01
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Half-band cascade

  iud_iq_t hb1_out;
  iud_iq_t hb2_out;
  iud_iq_t hb3_out;

  iud_hb_stage #(
    .PRE_UNIT(`IUD_HB1_PRE_UNIT),
    .POST_UNIT(`IUD_HB1_POST_UNIT)
  ) u_first_halfband_stage (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_en(en1),
    .i_lo({1'h0, hb1_mode_reg[0]}), // RULE_05 RULE_06
    .i_mod(hb1_mode_reg[1]),
    .i_in_stb(tick_in),
    .i_out_stb(tick_hb1),
    .i_in(premod_reg),
    .o_out(hb1_out)
  );

  iud_hb_stage u_second_halfband_stage (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_en(en2),
    .i_lo(hb2_mode_reg[1:0]), // RULE_05 RULE_08
    .i_mod(hb2_mode_reg[2]),
    .i_in_stb(tick_hb1),
    .i_out_stb(tick_hb2),
    .i_in(hb1_out),
    .o_out(hb2_out)
  );

  iud_hb_stage u_third_halfband_stage (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_en(en3),
    .i_lo(hb3_mode_reg[1:0]), // RULE_10
    .i_mod(hb3_mode_reg[2]),
    .i_in_stb(tick_hb2),
    .i_out_stb(tick_hb3),
    .i_in(hb2_out),
    .o_out(hb3_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // Oscillator and quadrature mixer

  logic [31:0] phase_reg;
  logic osc_tick;

  // Oscillator runs at the first stage output rate
  assign osc_tick = en1 ? tick_hb1 : tick_in; // RULE_13

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_reg <= 32'h0000_0000;
    else if (osc_tick)
      phase_reg <= phase_reg + ftw_active_reg; // RULE_14
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_out <= '0;
      o_out_valid <= 1'h0;
    end
    else
    begin
      o_out_valid <= tick_hb3 && started_reg; // RULE_20
      if (tick_hb3)
        o_out <= iud_rot(hb3_out, phase_reg[31:26]); // RULE_15 RULE_16
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  logic cfg_wr;
  assign cfg_wr = i_reg_wr && (i_reg_addr == `IUD_OFS_CFG);

  sequence s_quiet7;
    !tick_in [*7];
  endsequence

  sequence s_word_taken;
    ftw_upd_reg && !ftw_upd_prev_reg;
  endsequence

  chk_ftw_take: assert property (s_word_taken |=> // RULE_17
    ftw_active_reg == {$past(ftw_shadow_reg[3]), $past(ftw_shadow_reg[2]),
      $past(ftw_shadow_reg[1]), $past(ftw_shadow_reg[0])})
    else $error("tuning word not taken on update edge");

  chk_ftw_hold: assert property (!ftw_take |=> $stable(ftw_active_reg)) // RULE_17
    else $error("tuning word changed without update edge");

  chk_nco_step: assert property (osc_tick |=> // RULE_14
    phase_reg == 32'($past(phase_reg) + $past(ftw_active_reg)))
    else $error("phase did not advance by tuning word");

  chk_nco_still: assert property (!osc_tick |=> $stable(phase_reg)) // RULE_13
    else $error("phase moved off oscillator tick");

  chk_nco_rate: assert property ((en1 && n_en == 2'h1 && !cfg_wr) |-> // RULE_13
    osc_tick)
    else $error("oscillator not at twice input rate");

  chk_ratio_eight: assert property (@(posedge i_clk)
    disable iff (!rst_n || cfg_wr)
    (tick_in && cfg_reg.stage_en[3:1] == 3'h7) |=> s_quiet7 ##1 tick_in) // RULE_02
    else $error("input period is not eight clocks");

  chk_pull_rate: assert property (pop |-> cnt_reg == 3'h0) // RULE_18
    else $error("sample pulled off the input period");

  chk_premod_sign: assert property (
    (pop && cfg_reg.stage_en[`IUD_BIT_PREMOD]) |=> // RULE_01
    premod_reg.i == ($past(alt_reg) ? 16'(-$past(fifo_data.i)) :
      $past(fifo_data.i)))
    else $error("premodulator sign wrong");

  chk_out_order: assert property ((tick_hb3 && started_reg) |=> // RULE_20
    o_out_valid ##0 o_out == iud_rot($past(hb3_out), $past(phase_reg[31:26])))
    else $error("mixer output not from third stage");
endmodule
`default_nettype wire

/* bench/iud_src_model.sv */
// Source model: offers I/Q pairs to the datapath input.
// Assumes ready is sampled on the rising edge of i_clk.
`timescale 1ns/1ns
`default_nettype none
module iud_src_model import iud_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire iud_iq_t i_base,
  input wire logic [15:0] i_step,
  input wire logic i_ready,
  output logic o_valid,
  output iud_iq_t o_data,
  output logic [15:0] o_taken
);
  logic [15:0] nn;
  assign nn = o_taken + 16'(o_valid && i_ready);
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_valid <= 1'b0;
      o_data <= '0;
      o_taken <= '0;
    end
    else
    begin
      o_taken <= nn;
      // A refused word is held until taken
      if (o_valid && !i_ready)
        o_valid <= 1'b1;
      else if (i_en)
      begin
        o_valid <= 1'b1;
        o_data.i <= 16'(i_base.i + nn * i_step);
        o_data.q <= 16'(i_base.q - 2 * nn * i_step);
      end
      else
      begin
        // Released lines flip between the inverse of the last word and the word itself each clock
        o_valid <= 1'b0;
        o_data <= ~o_data;
      end
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench of the upconversion datapath.
// Assumes the source model feeds the data input.
`timescale 1ns/1ns
`default_nettype none
module testbench import iud_pkg::*;;
  logic clk, nrst, src_rst_n, en, wr, vld, rdy, ovld;
  logic [7:0] addr, wdata, rdata;
  logic [15:0] step, taken;
  iud_iq_t base, dat, out;
  iud_iq_t ring [4];
  int n_mismatch, samples_checked;
  localparam logic [7:0] RA [9] = '{8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h30,
    8'h31, 8'h32, 8'h33, 8'h37};

  iud_datapath dut_u (.i_clk(clk), .i_nrst(nrst), .i_in_valid(vld),
    .i_in_data(dat), .o_in_ready(rdy), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata),
    .o_out(out), .o_out_valid(ovld));
  iud_src_model src_u (.i_clk(clk), .i_rst_n(src_rst_n), .i_en(en),
    .i_base(base), .i_step(step), .i_ready(rdy), .o_valid(vld),
    .o_data(dat), .o_taken(taken));

  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a, exp);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1;
    check(nm, 32'(rdata), 32'(exp));
  endtask

  // Unity gain of the mixer at zero phase is just below one
  function automatic logic [15:0] scl(input logic signed [15:0] x);
    logic signed [31:0] p;
    p = x * 16'sh7fff;
    return p[30:15];
  endfunction

  function automatic iud_iq_t ex(input int k);
    return {scl(16'(16'h0100 + k)), scl(16'(16'h0200 - 2 * k))};
  endfunction

  function automatic int ridx(input iud_iq_t v);
    for (int k = 0; k < 4; k++)
      if (v === ring[k])
        return k;
    return 4;
  endfunction

  // Output must walk the quarter-turn ring by st steps per clock
  task automatic ring_chk(input string nm, input int st);
    int p;
    int t;
    repeat (12) @(posedge clk);
    t = 0;
    do
    begin
      @(posedge clk);
      #1;
      p = ridx(out);
      t++;
    end
    while (p == 4 && t < 60);
    check(nm, 32'(p < 4), 32'h1);
    for (int k = 1; k < 7; k++)
    begin
      @(posedge clk);
      #1;
      check(nm, out, ring[(p + st * k) % 4]);
    end
  endtask

  task automatic src_go(input logic [15:0] bi, bq, st);
    @(posedge clk);
    en <= 1'b0;
    src_rst_n <= 1'b0;
    @(posedge clk);
    src_rst_n <= 1'b1;
    base <= {bi, bq};
    step <= st;
    @(posedge clk);
    en <= 1'b1;
  endtask

  task automatic carrier_tuning_word_part0(input logic [31:0] w);
    for (int b = 0; b < 4; b++)
      wr_reg(8'(8'h30 + b), w[8*b+:8]);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    check("ready", 32'(rdy), 32'h1);
    check("out valid", 32'(ovld), 32'h0);
    for (int k = 0; k < 9; k++)
      chk_reg("reset", RA[k], 8'h00);
    for (int k = 0; k < 4; k++)
      wr_reg(8'(8'h30 + k), 8'(8'h11 * (k + 1)));
    for (int k = 0; k < 4; k++)
      chk_reg("word byte", 8'(8'h30 + k), 8'(8'h11 * (k + 1)));
    for (int m = 0; m < 8; m++)
    begin
      wr_reg(8'h1c, 8'(m) | 8'hfc);
      wr_reg(8'h1d, {2'h3, 3'(m), 3'(m)});
      wr_reg(8'h1e, {2'h3, 3'(m), 3'(m)});
      chk_reg("mode one", 8'h1c, 8'(m % 4));
      chk_reg("mode two", 8'h1d, {2'h0, 3'(m), 3'(m)});
      chk_reg("mode three", 8'h1e, {2'h0, 3'(m), 3'(m)});
    end
    wr_reg(8'h40, 8'ha5);
    chk_reg("unmapped", 8'h40, 8'h00);
  endtask

  task automatic t_bypass;
    int t;
    src_go(16'h0100, 16'h0200, 16'h0001);
    t = 0;
    do
    begin
      @(posedge clk);
      #1;
      t++;
    end
    while (out !== ex(0) && t < 60);
    check("bypass lock", 32'(t < 60), 32'h1);
    for (int k = 1; k < 7; k++)
    begin
      @(posedge clk);
      #1;
      check("bypass", out, ex(k));
    end
    check("out valid", 32'(ovld), 32'h1);
  endtask

  task automatic t_mix;
    src_go(16'h1000, 16'h0000, 16'h0000);
    wr_reg(8'h1b, 8'h01);
    ring_chk("premod", 2);
    wr_reg(8'h1b, 8'h00);
    ring_chk("word zero", 0);
    carrier_tuning_word_part0(32'h4000_0000);
    ring_chk("word held", 0);
    wr_reg(8'h36, 8'h01);
    ring_chk("quarter", 1);
    carrier_tuning_word_part0(32'h8000_0000);
    wr_reg(8'h36, 8'h01);
    ring_chk("no edge", 1);
    wr_reg(8'h36, 8'h00);
    wr_reg(8'h36, 8'h01);
    ring_chk("half", 2);
  endtask

  task automatic t_rate;
    logic [15:0] t0;
    int t;
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(8'h1b, 8'(((1 << s) - 1) << 1));
      repeat (40) @(posedge clk);
      #1;
      t0 = taken;
      repeat (16 << s) @(posedge clk);
      #1;
      t0 = 16'(taken - t0);
      check("pull rate", 32'(t0 > 14 && t0 < 18), 32'h1);
    end
    for (int f = 0; f < 2; f++)
    begin
      @(posedge clk);
      en <= 1'b0;
      repeat (120) @(posedge clk);
      chk_reg("level", 8'h37, 8'h30);
      check("ready empty", 32'(rdy), 32'h1);
      @(posedge clk);
      en <= 1'b1;
      t = 0;
      do
      begin
        @(posedge clk);
        #1;
        t++;
      end
      while (rdy !== 1'b0 && t < 30);
      check("fifo full", 32'(t < 30), 32'h1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end

  initial
  begin
    {nrst, src_rst_n, en, wr, addr, wdata, base, step} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    ring[0] = {scl(16'sh1000), 16'h0000};
    ring[1] = {16'h0000, scl(16'sh1000)};
    ring[2] = {scl(-16'sh1000), 16'h0000};
    ring[3] = {16'h0000, scl(-16'sh1000)};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    src_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_regs;
    t_bypass;
    t_mix;
    t_rate;
    end_of_test;
  end
endmodule
`default_nettype wire
